/* File: rtl/cgx_alu.v */
// Combinational 32-bit add-with-carry and logic core of the execution unit.
`timescale 1ns/1ps
`default_nettype none
`include "cgx_map.vh"
module cgx_alu #(
  parameter W = 32
) (
  input  wire [5:0]   op,
  input  wire [W-1:0] dst_val,
  input  wire [W-1:0] src_val,
  input  wire         c_in,
  input  wire         z_in,
  output reg  [W-1:0] result,
  output reg          z_out,
  output reg          c_out
);
  reg [W:0] sum;

  always @* begin
    sum    = {(W+1){1'b0}};
    result = {W{1'b0}};
    z_out  = z_in;
    c_out  = c_in;
    case (op)
      `CGX_OP_ADD_CARRY: begin
        sum    = {1'b0, dst_val} + {1'b0, src_val} + {{W{1'b0}}, c_in};
        result = sum[W-1:0];
        z_out  = z_in & (sum[W-1:0] == {W{1'b0}});
        c_out  = sum[W];
      end
      `CGX_OP_AND: begin
        result = dst_val & src_val;
        z_out  = (result == {W{1'b0}});
        c_out  = ^result;
      end
      `CGX_OP_AND_INVERTED: begin
        result = dst_val & ~src_val;
        z_out  = (result == {W{1'b0}});
        c_out  = ^result;
      end
      default: begin
        result = dst_val;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/cgx_exec_unit.v */
// Execution unit for add-with-carry, and, and-inverted and link-and-jump.
// Function
// - Add-with-carry sums destination, source and carry flag unsigned into destination.
// - Second operand is a register or a zero-extended 9-bit literal per immediate bit.
// - Add-with-carry zero flag becomes 1 only if already 1 and sum zero.
// - Add-with-carry carry flag is the 32-bit unsigned overflow.
// - Result is written back unless the no-result-write effect is selected.
// - And gives destination and source; zero flag set when result is zero.
// - And and and-inverted carry flag is odd parity of the result.
// - And-inverted ands destination with inverted source; zero flag on zero result.
// - And-inverted decodes opcode 011001, condition 1111, finishes in 4 clocks.
// - Add-with-carry opcode 110010, and opcode 011000, both use immediate bit.
// - Link-and-jump writes return address into low 9 bits, upper bits kept.
// - Link-and-jump stores the return address and loads the target in the same cycle.
// - Link-and-jump carry flag is 1 unless incremented counter wraps to 0.
// - Link-and-jump decodes opcode 010111, condition 1111, executes in 4 clocks.
// - No return stack; a nested call overwrites the earlier return address.
// - Return is a plain jump using its source field as last written.
// - Link-and-jump shares jump-and-link opcode, only immediate bit forced to one.
`timescale 1ns/1ps
`default_nettype none
`include "cgx_map.vh"
module cgx_exec_unit #(
  parameter W  = 32,
  parameter AW = 9
) (
  input  wire          clk_sys,
  input  wire          rst,
  input  wire          ce,
  input  wire          instr_valid,
  input  wire [31:0]   instr,
  input  wire [AW-1:0] pc,
  input  wire [W-1:0]  dst_val,
  input  wire [W-1:0]  src_reg_val,
  output reg           busy_r,
  output reg           done_r,
  output reg           accepted_r,
  output reg           wr_en_r,
  output reg  [AW-1:0] wr_addr_r,
  output reg  [W-1:0]  wr_data_r,
  output reg           pc_load_r,
  output reg  [AW-1:0] pc_target_r,
  output reg           flag_z_r,
  output reg           flag_c_r
);
  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_DONE = 3'b100;
  // One issue cycle, two execute cycles and one done cycle make up the
  // four clocks of every instruction; the done cycle registers result and
  // flags so that every output comes straight from a flip-flop.

  reg  [2:0]    state_r;
  reg  [2:0]    state_nxt;
  reg  [2:0]    cnt_r;
  reg  [31:0]   ins_r;
  reg  [AW-1:0] pc_r;
  reg  [W-1:0]  dval_r;
  reg  [W-1:0]  sval_r;

  wire [5:0]    op_f  = ins_r[`CGX_F_OP_HI:`CGX_F_OP_LO];
  wire          zero_flag_write_effect  = ins_r[`CGX_F_ZERO_WR];
  wire          carry_flag_write_effect = ins_r[`CGX_F_CARRY_WR];
  wire          wr_f  = ins_r[`CGX_F_WR];
  wire [AW-1:0] dst_f = ins_r[`CGX_F_DST_HI:`CGX_F_DST_LO];
  wire [AW-1:0] src_f = ins_r[`CGX_F_SRC_HI:`CGX_F_SRC_LO];

  // True when the condition field says the instruction always runs.
  function cond_always;
    input [31:0] iw;
    begin
      cond_always = (iw[`CGX_F_COND_HI:`CGX_F_COND_LO] == `CGX_COND_ALWAYS);
    end
  endfunction

  // Returns 1 for add-with-carry and and, for and-inverted only under the always condition,
  // and for link-and-jump only under the always condition with the immediate bit set;
  // any other word is left to the rest of the core and never accepted.
  function supported;
    input [31:0] iw;
    begin
      case (iw[`CGX_F_OP_HI:`CGX_F_OP_LO])
        `CGX_OP_ADD_CARRY: begin
          supported = 1'b1;
        end
        `CGX_OP_AND: begin
          supported = 1'b1;
        end
        `CGX_OP_AND_INVERTED: begin
          supported = cond_always(iw);
        end
        `CGX_OP_JUMP_LINK: begin
          supported = iw[`CGX_F_IMM] && cond_always(iw);
        end
        default: begin
          supported = 1'b0;
        end
      endcase
    end
  endfunction

  // Zero-extends a nine-bit literal to the data width.
  function [W-1:0] zext;
    input [AW-1:0] v;
    begin
      zext = {{(W-AW){1'b0}}, v};
    end
  endfunction

  wire          jl_op    = (op_f == `CGX_OP_JUMP_LINK);
  wire          issue    = (state_r == ST_IDLE) && instr_valid &&
                           supported(instr);
  wire          finish   = (state_r == ST_DONE);
  wire [W-1:0]  alu_res;
  wire          alu_z;
  wire          alu_c;
  wire [AW-1:0] ret_addr = pc_r + {{(AW-1){1'b0}}, 1'b1};
  wire [W-1:0]  src_pick = instr[`CGX_F_IMM] ?
                           zext(instr[`CGX_F_SRC_HI:`CGX_F_SRC_LO]) :
                           src_reg_val;

  reg  [W-1:0]  result_nxt;
  reg           flag_z_nxt;
  reg           flag_c_nxt;

  // Splices the return address into the low field of the link word.
  function [W-1:0] link_word;
    input [W-1:0]  word;
    input [AW-1:0] addr;
    begin
      link_word = {word[W-1:AW], addr};
    end
  endfunction

  cgx_alu #(
    .W (W)
  ) u_alu (
    .op      (op_f),
    .dst_val (dval_r),
    .src_val (sval_r),
    .c_in    (flag_c_r),
    .z_in    (flag_z_r),
    .result  (alu_res),
    .z_out   (alu_z),
    .c_out   (alu_c)
  );

  // Result and flags that the done cycle registers.
  always @* begin
    result_nxt = alu_res;
    flag_z_nxt = flag_z_r;
    flag_c_nxt = flag_c_r;
    if (jl_op) begin
      // Only the low nine bits change, so the return word keeps its
      // opcode and simply becomes a jump back to the caller.
      result_nxt = link_word(dval_r, ret_addr);
      if (zero_flag_write_effect) begin
        flag_z_nxt = (result_nxt == {W{1'b0}});
      end
      if (carry_flag_write_effect) begin
        flag_c_nxt = (ret_addr != {AW{1'b0}});
      end
    end else begin
      if (zero_flag_write_effect) begin
        flag_z_nxt = alu_z;
      end
      if (carry_flag_write_effect) begin
        flag_c_nxt = alu_c;
      end
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (issue) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (cnt_r == `CGX_EXEC_CLOCKS - 3'h3) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // The counter only runs while executing, so it never needs a wrap guard.
  always @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= 3'h0;
    end else if (ce) begin
      if (issue) begin
        cnt_r <= 3'h0;
      end else if (state_r == ST_EXEC) begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

  // Operands are latched at issue so later register writes cannot
  // disturb an instruction already in flight.
  always @(posedge clk_sys) begin
    if (rst) begin
      ins_r <= 32'h0;
    end else if (ce && issue) begin
      ins_r <= instr;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      pc_r <= {AW{1'b0}};
    end else if (ce && issue) begin
      pc_r <= pc;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      dval_r <= {W{1'b0}};
    end else if (ce && issue) begin
      dval_r <= dst_val;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      sval_r <= {W{1'b0}};
    end else if (ce && issue) begin
      sval_r <= src_pick;
    end
  end

  // Busy drops with the done pulse, so a new word may be offered in the
  // very next cycle.
  always @(posedge clk_sys) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      if (issue) begin
        busy_r <= 1'b1;
      end else if (state_r != ST_EXEC) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Each pulse output stands for exactly one cycle; the sequencer must
  // sample it on the edge that follows.
  always @(posedge clk_sys) begin
    if (rst) begin
      accepted_r <= 1'b0;
    end else if (ce) begin
      accepted_r <= issue;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= finish;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      wr_en_r <= 1'b0;
    end else if (ce) begin
      wr_en_r <= finish && wr_f;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      pc_load_r <= 1'b0;
    end else if (ce) begin
      pc_load_r <= finish && jl_op;
    end
  end

  // Result and address hold until the next instruction finishes, the target until the next link-and-jump finishes.
  always @(posedge clk_sys) begin
    if (rst) begin
      wr_addr_r <= {AW{1'b0}};
    end else if (ce && finish) begin
      wr_addr_r <= dst_f;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      wr_data_r <= {W{1'b0}};
    end else if (ce && finish) begin
      wr_data_r <= result_nxt;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      pc_target_r <= {AW{1'b0}};
    end else if (ce && finish && jl_op) begin
      pc_target_r <= src_f;
    end
  end

  // Flags change only with their write effect, even with no write-back.
  always @(posedge clk_sys) begin
    if (rst) begin
      flag_z_r <= `CGX_RST_FLAGS;
    end else if (ce && finish) begin
      flag_z_r <= flag_z_nxt;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      flag_c_r <= `CGX_RST_FLAGS;
    end else if (ce && finish) begin
      flag_c_r <= flag_c_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/cgx_map.vh */
// Constants for the cog add, logic and link-and-jump execution unit.
`ifndef CGX_MAP_VH
`define CGX_MAP_VH
`define CGX_OP_ADD_CARRY    6'h32
`define CGX_OP_AND          6'h18
`define CGX_OP_AND_INVERTED 6'h19
`define CGX_OP_JUMP_LINK    6'h17
`define CGX_COND_ALWAYS     4'hf
`define CGX_F_OP_HI         31
`define CGX_F_OP_LO         26
`define CGX_F_ZERO_WR       25
`define CGX_F_CARRY_WR      24
`define CGX_F_WR            23
`define CGX_F_IMM           22
`define CGX_F_COND_HI       21
`define CGX_F_COND_LO       18
`define CGX_F_DST_HI        17
`define CGX_F_DST_LO        9
`define CGX_F_SRC_HI        8
`define CGX_F_SRC_LO        0
`define CGX_EXEC_CLOCKS     3'h4
`define CGX_RST_FLAGS       1'h0
`endif

/* File: testbench/cgx_exec_unit_properties.sv */
// Port-level assertions for the execution unit.
`timescale 1ns/1ps
`default_nettype none
module cgx_exec_unit_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        instr_valid,
  input wire logic [31:0] instr,
  input wire logic [8:0]  pc,
  input wire logic        busy_r,
  input wire logic        done_r,
  input wire logic        accepted_r,
  input wire logic        wr_en_r,
  input wire logic        pc_load_r,
  input wire logic [8:0]  pc_target_r,
  input wire logic        flag_c_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire [5:0] op = instr[31:26];
  wire       al = instr[21:18] == 4'hf;
  wire       go = ce && !busy_r && instr_valid && (op == 6'h32 ||
    op == 6'h18 || op == 6'h19 && al || op == 6'h17 && al && instr[22]);
  wire       jl = go && op == 6'h17;
  sequence s_run;
    ##1 accepted_r && busy_r ##3 done_r && !busy_r;
  endsequence
  chk_issue_timing: assert property (go |-> s_run)
    else $error("issue timing");
  chk_done_cause: assert property (done_r |-> $past(go, 4))
    else $error("done without issue");
  chk_busy_refuse: assert property (busy_r |=> !accepted_r)
    else $error("taken while busy");
  chk_load_link: assert property (pc_load_r |-> done_r &&
    $past(op, 4) == 6'h17) else $error("stray jump");
  chk_jump_target: assert property (jl |-> ##4 pc_load_r &&
    pc_target_r == $past(instr[8:0], 4)) else $error("jump target");
  chk_write_gate: assert property (done_r |->
    wr_en_r == $past(instr[23], 4)) else $error("write enable");
  chk_carry_kept: assert property (done_r && !$past(instr[24], 4) |->
    flag_c_r == $past(flag_c_r)) else $error("carry changed");
  chk_link_carry: assert property (jl && instr[24] |-> ##4
    flag_c_r == ($past(pc, 4) != 9'h1ff)) else $error("link carry");
endmodule
bind cgx_exec_unit cgx_exec_unit_chk chk (.*);
`default_nettype wire

/* File: testbench/cgx_exec_unit_test.sv */
// Scenario bench for the execution unit.
`timescale 1ns/1ps
`default_nettype none
module cgx_exec_unit_test;
  logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, instr_valid = 1'b0;
  logic [31:0] instr = 32'h0, dst_val, src_reg_val, wr_data_r;
  logic [8:0] pc = 9'h0, wr_addr_r, pc_target_r;
  logic busy_r, done_r, accepted_r, wr_en_r, pc_load_r, flag_z_r, flag_c_r;
  int miscompares = 0, checked = 0;
  cgx_exec_unit uut (.*);
  cgx_regfile_model pm (.*);
  initial forever #25 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input [31:0] e, g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // The f argument holds the expected zero, carry and write bits.
  task automatic run(input [31:0] w, input [8:0] p, input [31:0] ed,
                     input [2:0] f);
    logic [31:0] old = pm.mem[w[17:9]];
    int n = 0;
    instr <= w;
    pc <= p;
    instr_valid <= 1'b1;
    do @(posedge clk_sys); while (accepted_r !== 1'b1 && ++n < 9);
    instr_valid <= 1'b0;
    do @(posedge clk_sys); while (done_r !== 1'b1 && ++n < 20);
    chk("result", ed, wr_data_r);
    chk("flags", {f, w[31:26] == 6'h17, 1'b1},
        {flag_z_r, flag_c_r, wr_en_r, pc_load_r, done_r});
    if (w[31:26] == 6'h17)
      chk("target", w[8:0], pc_target_r);
    @(posedge clk_sys);
    chk("register", f[0] ? ed : old, pm.mem[w[17:9]]);
  endtask
  task automatic t_addx;
    run({6'h18,4'hb,4'hf,9'h0,9'h0}, 9'h0, 32'h0, 3'b101);
    run({6'h32,4'hf,4'hf,9'h1,9'h2}, 9'h1, 32'h0, 3'b111);
    run({6'h32,4'hf,4'hf,9'h2,9'h2}, 9'h2, 32'h0, 3'b111);
    run({6'h32,4'hc,4'hf,9'h3,9'h1}, 9'h3, 32'hffff_fffd, 3'b000);
  endtask
  task automatic t_logic;
    run({6'h18,4'hf,4'hf,9'h7,9'hf}, 9'h4, 32'h8, 3'b011);
    run({6'h19,4'hf,4'hf,9'h8,9'h7}, 9'h5, 32'hffff_fff0, 3'b001);
    run({6'h19,4'he,4'hf,9'h9,9'ha}, 9'h6, 32'h2, 3'b011);
  endtask
  task automatic t_link;
    run({6'h17,4'h7,4'hf,9'hc,9'h55}, 9'h1ff, 32'hffff_fe00, 3'b001);
    run({6'h17,4'h7,4'hf,9'hc,9'haa}, 9'h20, 32'hffff_fe21, 3'b011);
  endtask
  task automatic t_refuse;
    instr <= {6'h19, 4'h3, 4'h0, 9'hd, 9'h0};
    instr_valid <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("refused", 2'b00, {busy_r, accepted_r});
    instr <= {6'h32, 4'hf, 4'hf, 9'hd, 9'h0};
    ce <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("frozen", 2'b00, {busy_r, accepted_r});
    ce <= 1'b1;
    instr_valid <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_addx();
    t_logic();
    t_link();
    t_refuse();
    final_report();
  end
  initial begin
    #20000;
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire

/* File: testbench/cgx_regfile_model.sv */
// Register memory standing behind the execution unit.
`timescale 1ns/1ps
`default_nettype none
module cgx_regfile_model (
  input  wire logic        clk_sys,
  input  wire logic [31:0] instr,
  input  wire logic        wr_en_r,
  input  wire logic [8:0]  wr_addr_r,
  input  wire logic [31:0] wr_data_r,
  output logic      [31:0] dst_val,
  output logic      [31:0] src_reg_val
);
  logic [31:0] mem [512];
  // Cells start as their inverted address, so no preload is needed.
  initial foreach (mem[i]) mem[i] = ~32'(i);
  assign dst_val = mem[instr[17:9]];
  assign src_reg_val = mem[instr[8:0]];
  always @(posedge clk_sys) if (wr_en_r) mem[wr_addr_r] <= wr_data_r;
endmodule
`default_nettype wire
